// ### core/edge_shaping_pkg.sv
// Package of register map, field layout and codes for the active edge shaper
package edge_shaping_pkg;

  // ****************************************
  // Register indices and address width
  // ****************************************
  localparam logic [15:0] IDX_EDGE_DURATION = 16'h0511;
  localparam logic [15:0] IDX_RESIDUAL_LEVEL = 16'h0512;
  localparam logic [15:0] IDX_EDGE_KIND = 16'h0513;
  localparam logic [15:0] IDX_EDGE_PROFILE = 16'h0514;
  localparam logic [15:0] IDX_SHAPER_CTRL = 16'h0518;
  localparam logic [15:0] IDX_SHAPER_STATUS = 16'h0519;
  localparam int ADDR_W = 18;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int DUR_DOUBLE_BIT = 7;
  localparam logic [7:0] DUR_WRITE_MASK = 8'h9F;
  localparam logic [7:0] PROFILE_WRITE_MASK = 8'h77;
  localparam logic [7:0] DUR_RESET = 8'h00;
  localparam logic [7:0] RESIDUAL_RESET = 8'h00;
  localparam logic [7:0] KIND_RESET = 8'h11;
  localparam logic [7:0] PROFILE_RESET = 8'h00;
  localparam logic [7:0] FULL_LEVEL = 8'hFF;

  // ****************************************
  // Edge kind codes
  // ****************************************
  localparam logic [3:0] KIND_FW_ONE = 4'h1;
  localparam logic [3:0] KIND_FW_THREE = 4'h3;
  localparam logic [3:0] KIND_LUT_PLAIN = 4'h4;
  localparam logic [3:0] KIND_LUT_CORR = 4'h5;
  localparam logic [3:0] KIND_LUT_NOCORR = 4'h6;

  // Decoded style of one edge
  typedef enum logic [2:0] {
    STYLE_RESERVED = 3'b001,
    STYLE_FIRMWARE = 3'b010,
    STYLE_LOOKUP = 3'b100
  } edge_style_t;

  // Shaper sequencer states
  typedef enum logic [3:0] {
    SH_HIGH = 4'b0001,
    SH_FALL = 4'b0010,
    SH_LOW = 4'b0100,
    SH_RISE = 4'b1000
  } shaper_state_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### core/edge_kind_decoder.sv
// Decoder of one edge kind nibble into style and options
`timescale 1ns/10ps
`default_nettype none
module edge_kind_decoder
  import edge_shaping_pkg::*;
(
  // Kind nibble and style field
  input wire logic [3:0] kind_i,
  input wire logic [2:0] style_field_i,
  // Decoded settings
  output edge_style_t style_o,
  output logic [1:0] segments_o,
  output logic [2:0] time_const_o,
  output logic [1:0] lut_index_o,
  output logic vdd_adapt_o,
  output logic vdd_correct_o
);

  always_comb begin
    style_o = STYLE_RESERVED;
    segments_o = 2'h0;
    time_const_o = 3'h0;
    lut_index_o = 2'h0;
    vdd_adapt_o = 1'b0;
    vdd_correct_o = 1'b0;
    if (kind_i >= KIND_FW_ONE && kind_i <= KIND_FW_THREE) begin
      style_o = STYLE_FIRMWARE; // R4 R6
      segments_o = kind_i[1:0];
      time_const_o = style_field_i; // R7 R9
    end else if (kind_i >= KIND_LUT_PLAIN && kind_i <= KIND_LUT_NOCORR) begin
      style_o = STYLE_LOOKUP; // R5 R6
      lut_index_o = style_field_i[1:0]; // R8 R9
      vdd_adapt_o = (kind_i == KIND_LUT_CORR) || (kind_i == KIND_LUT_NOCORR);
      vdd_correct_o = (kind_i == KIND_LUT_CORR);
    end
  end

endmodule // edge_kind_decoder
`default_nettype wire

// ### core/edge_step_timer.sv
// Transition state timer: one pulse per state, one or two carrier cycles long
`timescale 1ns/10ps
`default_nettype none
module edge_step_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  input wire logic double_i,
  // State step
  output logic step_o
);

  logic half_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !run_i) begin
      half_reg <= 1'b0;
    end else if (double_i) begin
      half_reg <= ~half_reg;
    end else begin
      half_reg <= 1'b0;
    end
  end

  // Step ends a state after one cycle, or two when doubled
  assign step_o = run_i && (!double_i || half_reg); // R1

endmodule // edge_step_timer
`default_nettype wire

// ### core/active_tx_edge_shaping_cfg.sv
// Active mode transmit edge shaper with AXI4-Lite configuration registers
// Summary of operation
// R1: Doubling bit makes each state two cycles
// R2: Five-bit state count shared by both edges
// R3: Eight-bit residual level, 00 none, FF full
// R4: Falling nibble 1..3 selects linear segments
// R5: Codes 4..6 select lookup table, supply options
// R6: Rising nibble uses the same encoding
// R7: Falling style field is firmware time constant
// R8: Falling style field picks lookup table 0..3
// R9: Rising style field acts the same way
// R10: Doubling in bit 7; reserved bits read zero
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module active_tx_edge_shaping_cfg
  import edge_shaping_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modulation request
  input wire logic mod_i,
  // Envelope output
  output logic [7:0] amplitude_o,
  output logic shaping_busy_o,
  output logic [1:0] lut_index_o,
  output logic vdd_adapt_o,
  output logic vdd_correct_o
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] duration_reg;
  logic [7:0] residual_reg;
  logic [7:0] kind_reg;
  logic [7:0] profile_reg;
  logic enable_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_value;
  logic rd_hit;

  // ****************************************
  // Write channel
  // ****************************************
  // A low ready flop means its address or data beat is held
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_awready <= 1'b1;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_wready <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (aw_addr_reg[ADDR_W-1:2] == IDX_EDGE_DURATION) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg[ADDR_W-1:2] == IDX_RESIDUAL_LEVEL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg[ADDR_W-1:2] == IDX_EDGE_KIND) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg[ADDR_W-1:2] == IDX_EDGE_PROFILE) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg[ADDR_W-1:2] == IDX_SHAPER_CTRL) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      duration_reg <= DUR_RESET;
      residual_reg <= RESIDUAL_RESET;
      kind_reg <= KIND_RESET;
      profile_reg <= PROFILE_RESET;
      enable_reg <= 1'b0;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg[ADDR_W-1:2] == IDX_EDGE_DURATION) begin
        duration_reg <= w_data_reg[7:0] & DUR_WRITE_MASK; // R10
      end else if (aw_addr_reg[ADDR_W-1:2] == IDX_RESIDUAL_LEVEL) begin
        residual_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg[ADDR_W-1:2] == IDX_EDGE_KIND) begin
        kind_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg[ADDR_W-1:2] == IDX_EDGE_PROFILE) begin
        profile_reg <= w_data_reg[7:0] & PROFILE_WRITE_MASK; // R10
      end else if (aw_addr_reg[ADDR_W-1:2] == IDX_SHAPER_CTRL) begin
        enable_reg <= w_data_reg[0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Decode of both edges
  // ****************************************
  edge_style_t fall_style;
  edge_style_t rise_style;
  logic [1:0] fall_segments;
  logic [1:0] rise_segments;
  logic [2:0] fall_tc;
  logic [2:0] rise_tc;
  logic [1:0] fall_lut;
  logic [1:0] rise_lut;
  logic fall_adapt;
  logic rise_adapt;
  logic fall_corr;
  logic rise_corr;

  edge_kind_decoder u_fall_decoder (
    .kind_i(kind_reg[7:4]),
    .style_field_i(profile_reg[6:4]),
    .style_o(fall_style),
    .segments_o(fall_segments),
    .time_const_o(fall_tc),
    .lut_index_o(fall_lut),
    .vdd_adapt_o(fall_adapt),
    .vdd_correct_o(fall_corr)
  );

  edge_kind_decoder u_rise_decoder (
    .kind_i(kind_reg[3:0]),
    .style_field_i(profile_reg[2:0]),
    .style_o(rise_style),
    .segments_o(rise_segments),
    .time_const_o(rise_tc),
    .lut_index_o(rise_lut),
    .vdd_adapt_o(rise_adapt),
    .vdd_correct_o(rise_corr)
  );

  // ****************************************
  // Edge sequencer
  // ****************************************
  shaper_state_t state_reg;
  logic [4:0] count_reg;
  logic step;
  logic running;
  logic [7:0] span;
  logic [7:0] target;
  logic [4:0] states;

  assign states = duration_reg[4:0]; // R2
  assign running = (state_reg == SH_FALL) || (state_reg == SH_RISE);
  assign span = FULL_LEVEL - residual_reg; // R3

  edge_step_timer u_step_timer (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .run_i(running),
    .double_i(duration_reg[DUR_DOUBLE_BIT]), // R1 R10
    .step_o(step)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_reg <= SH_HIGH;
      count_reg <= 5'h00;
    end else begin
      case (state_reg)
        SH_HIGH: begin
          if (enable_reg && mod_i) begin
            state_reg <= (states == 5'h00 || fall_style == STYLE_RESERVED) ? SH_LOW : SH_FALL;
            count_reg <= 5'h00;
          end
        end
        SH_FALL: begin
          if (step) begin
            if (count_reg == states - 5'h01) begin
              state_reg <= SH_LOW; // R2
            end
            count_reg <= count_reg + 5'h01;
          end
        end
        SH_LOW: begin
          if (!mod_i || !enable_reg) begin
            state_reg <= (states == 5'h00 || rise_style == STYLE_RESERVED) ? SH_HIGH : SH_RISE;
            count_reg <= 5'h00;
          end
        end
        SH_RISE: begin
          if (step) begin
            if (count_reg == states - 5'h01) begin
              state_reg <= SH_HIGH; // R2
            end
            count_reg <= count_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= SH_HIGH;
        end
      endcase
    end
  end

  // Linear interpolation; more segments hold each level over that many states
  function automatic logic [7:0] ramp(input logic [7:0] sp, input logic [4:0] k, input logic [4:0] n,
                                      input logic [1:0] seg);
    logic [12:0] prod;
    logic [4:0] kq;
    prod = '0;
    kq = k;
    if (n != 5'h00) begin
      if (seg <= 2'h1) begin
        kq = k;
      end else begin
        kq = k - (k % {3'h0, seg});
      end
      prod = 13'(sp * kq) / 13'(n);
    end
    return prod[7:0];
  endfunction

  always_comb begin
    target = FULL_LEVEL;
    case (state_reg)
      SH_HIGH: target = FULL_LEVEL;
      SH_FALL: target = FULL_LEVEL - ramp(span, count_reg, states, fall_segments); // R4
      SH_LOW: target = residual_reg; // R3
      SH_RISE: target = residual_reg + ramp(span, count_reg, states, rise_segments); // R6
      default: target = FULL_LEVEL;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      amplitude_o <= FULL_LEVEL;
      shaping_busy_o <= 1'b0;
      lut_index_o <= 2'h0;
      vdd_adapt_o <= 1'b0;
      vdd_correct_o <= 1'b0;
    end else begin
      amplitude_o <= target;
      shaping_busy_o <= running;
      if (state_reg == SH_RISE || state_reg == SH_LOW) begin
        lut_index_o <= rise_lut; // R9
        vdd_adapt_o <= rise_adapt; // R5
        vdd_correct_o <= rise_corr;
      end else begin
        lut_index_o <= fall_lut; // R8
        vdd_adapt_o <= fall_adapt; // R5
        vdd_correct_o <= fall_corr;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr[ADDR_W-1:2] == IDX_EDGE_DURATION) begin
      rd_value = {24'h000000, duration_reg};
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_RESIDUAL_LEVEL) begin
      rd_value = {24'h000000, residual_reg};
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_EDGE_KIND) begin
      rd_value = {24'h000000, kind_reg};
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_EDGE_PROFILE) begin
      rd_value = {24'h000000, profile_reg};
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_SHAPER_CTRL) begin
      rd_value = {31'h0000_0000, enable_reg};
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_SHAPER_STATUS) begin
      rd_value = {9'h000, fall_tc, rise_tc, count_reg, state_reg, amplitude_o};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_single_cycle_state;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (running && !duration_reg[DUR_DOUBLE_BIT]) |-> step;
  endproperty
  a_single_cycle_state: assert property (p_single_cycle_state) else $error("state not one cycle"); // R1

  property p_double_cycle_state;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (running && duration_reg[DUR_DOUBLE_BIT] && step) |=> !step;
  endproperty
  a_double_cycle_state: assert property (p_double_cycle_state) else $error("state not two cycles"); // R1

  property p_count_bound;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      running |-> (count_reg < states);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("state count exceeded"); // R2

  property p_residual_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == SH_LOW) |=> (amplitude_o == $past(residual_reg));
  endproperty
  a_residual_hold: assert property (p_residual_hold) else $error("residual level wrong"); // R3

  property p_full_idle;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == SH_HIGH) |=> (amplitude_o == FULL_LEVEL);
  endproperty
  a_full_idle: assert property (p_full_idle) else $error("idle not full carrier"); // R3

  property p_reserved_fall_skips;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == SH_HIGH && fall_style == STYLE_RESERVED) |=> (state_reg != SH_FALL);
  endproperty
  a_reserved_fall_skips: assert property (p_reserved_fall_skips) else $error("reserved kind shaped"); // R4

  property p_lut_options;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == SH_FALL && kind_reg[7:4] == KIND_LUT_CORR) |=> (vdd_adapt_o && vdd_correct_o);
  endproperty
  a_lut_options: assert property (p_lut_options) else $error("supply options wrong"); // R5

  property p_rise_lut;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_reg == SH_RISE && rise_style == STYLE_LOOKUP) |=> (lut_index_o == $past(profile_reg[1:0]));
  endproperty
  a_rise_lut: assert property (p_rise_lut) else $error("rising table index wrong"); // R9

  property p_reserved_read_zero;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (duration_reg[6:5] == 2'h0) && (profile_reg[7] == 1'b0) && (profile_reg[3] == 1'b0);
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero) else $error("reserved bits stored"); // R10

  c_fall_edge: cover property (@(posedge sys_clk_i) state_reg == SH_FALL ##1 state_reg == SH_LOW);
  c_rise_edge: cover property (@(posedge sys_clk_i) state_reg == SH_RISE ##1 state_reg == SH_HIGH);
  c_doubled: cover property (@(posedge sys_clk_i) running && duration_reg[DUR_DOUBLE_BIT] && step);

endmodule // active_tx_edge_shaping_cfg
`default_nettype wire

// ### tb/active_tx_edge_shaping_cfg_bench.sv
// Self-checking bench for the active edge shaper and its register block
`timescale 1ns/10ps
`default_nettype none
module active_tx_edge_shaping_cfg_bench
  import edge_shaping_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct packed {
    logic [7:0] dur;
    logic [7:0] res;
    logic [7:0] kind;
    logic [7:0] prof;
    logic [7:0] rdur;
    logic [7:0] rprof;
    logic [7:0] fb;
    logic [7:0] rb;
    logic lut;
    logic [3:0] fcfg;
    logic [3:0] rcfg;
  } row_t;
  logic sys_clk_i;
  logic nrst_i;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, lut_index_o;
  logic mod_i, shaping_busy_o, vdd_adapt_o, vdd_correct_o;
  logic [7:0] amplitude_o, lv;
  logic [31:0] v;
  logic [3:0] cfg;
  int fails, compares, cycles, n;
  row_t rows [9] = '{
    '{8'h02, 8'h40, 8'h11, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02, 1'b0, 4'h0, 4'h0},
    '{8'h82, 8'h80, 8'h23, 8'h77, 8'h82, 8'h77, 8'h04, 8'h04, 1'b0, 4'h0, 4'h0},
    '{8'hFF, 8'h00, 8'h33, 8'hFF, 8'h9F, 8'h77, 8'h3E, 8'h3E, 1'b0, 4'h0, 4'h0},
    '{8'h00, 8'hFF, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0, 4'h0},
    '{8'h03, 8'h10, 8'h56, 8'h21, 8'h03, 8'h21, 8'h03, 8'h03, 1'b1, 4'hB, 4'h6},
    '{8'h04, 8'h20, 8'h64, 8'h03, 8'h04, 8'h03, 8'h04, 8'h04, 1'b1, 4'h2, 4'hC},
    '{8'h02, 8'h30, 8'h45, 8'h10, 8'h02, 8'h10, 8'h02, 8'h02, 1'b1, 4'h4, 4'h3},
    '{8'h05, 8'h50, 8'h70, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0, 4'h0},
    '{8'h02, 8'h60, 8'h1F, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 1'b0, 4'h0, 4'h0}
  };

  active_tx_edge_shaping_cfg i_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mod_i(mod_i),
    .amplitude_o(amplitude_o), .shaping_busy_o(shaping_busy_o), .lut_index_o(lut_index_o),
    .vdd_adapt_o(vdd_adapt_o), .vdd_correct_o(vdd_correct_o)
  );

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  function automatic logic [ADDR_W-1:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ready levels only move at rising edges, so the falling edge shows what the next edge samples
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] st, output logic [1:0] r);
    logic a, w, b;
    s_axi_awaddr <= ba(idx);
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge sys_clk_i);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge sys_clk_i);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a, b;
    s_axi_araddr <= ba(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge sys_clk_i);
      a = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk_i);
      if (a) s_axi_arvalid <= 1'b0;
    end
  endtask

  // Counts busy cycles of one edge and keeps the edge settings seen in its first busy cycle
  task automatic run_edge(input logic m, output int cnt, output logic [3:0] c, output logic [7:0] l);
    cnt = 0;
    c = 4'h0;
    l = 8'h00;
    mod_i <= m;
    repeat (80) begin
      @(negedge sys_clk_i);
      l = amplitude_o;
      if (shaping_busy_o === 1'b1) begin
        if (cnt == 0) c = {lut_index_o, vdd_adapt_o, vdd_correct_o};
        cnt++;
      end
    end
    @(posedge sys_clk_i);
  endtask

  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, mod_i} <= '0;
    fails = 0;
    compares = 0;
    do_reset();
    wr(IDX_SHAPER_CTRL, 8'h01, 4'hF, rsp);
    foreach (rows[i]) begin
      wr(IDX_EDGE_DURATION, rows[i].dur, 4'hF, rsp);
      wr(IDX_RESIDUAL_LEVEL, rows[i].res, 4'hF, rsp);
      wr(IDX_EDGE_KIND, rows[i].kind, 4'hF, rsp);
      wr(IDX_EDGE_PROFILE, rows[i].prof, 4'hF, rsp);
      chk("write response", {30'h0, RESP_OKAY}, {30'h0, rsp});
      rd(IDX_EDGE_DURATION, v, rsp);
      chk("duration", {24'h0, rows[i].rdur}, v);
      rd(IDX_EDGE_PROFILE, v, rsp);
      chk("profile", {24'h0, rows[i].rprof}, v);
      rd(IDX_EDGE_KIND, v, rsp);
      chk("kind", {24'h0, rows[i].kind}, v);
      run_edge(1'b1, n, cfg, lv);
      chk("fall busy", {24'h0, rows[i].fb}, 32'(n));
      chk("fall level", {24'h0, rows[i].res}, {24'h0, lv});
      if (rows[i].lut) chk("fall settings", {28'h0, rows[i].fcfg}, {28'h0, cfg});
      run_edge(1'b0, n, cfg, lv);
      chk("rise busy", {24'h0, rows[i].rb}, 32'(n));
      chk("rise level", {24'h0, FULL_LEVEL}, {24'h0, lv});
      if (rows[i].lut) chk("rise settings", {28'h0, rows[i].rcfg}, {28'h0, cfg});
    end
    // Time constants of both firmware edges show in the status word
    wr(IDX_EDGE_KIND, 8'h23, 4'hF, rsp);
    wr(IDX_EDGE_PROFILE, 8'h53, 4'hF, rsp);
    rd(IDX_SHAPER_STATUS, v, rsp);
    chk("status", 32'h005601FF, v);
    // Strobe zero changes nothing, unmapped index is refused
    wr(IDX_RESIDUAL_LEVEL, 8'h77, 4'h0, rsp);
    rd(IDX_RESIDUAL_LEVEL, v, rsp);
    chk("masked write", 32'h00000060, v);
    wr(16'h0515, 8'h12, 4'hF, rsp);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(16'h0515, v, rsp);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // Disabled shaper keeps the full carrier
    wr(IDX_SHAPER_CTRL, 8'h00, 4'hF, rsp);
    run_edge(1'b1, n, cfg, lv);
    chk("disabled busy", 32'h0, 32'(n));
    chk("disabled level", {24'h0, FULL_LEVEL}, {24'h0, lv});
    mod_i <= 1'b0;
    // Second reset restores register defaults
    do_reset();
    @(negedge sys_clk_i);
    chk("reset level", {24'h0, FULL_LEVEL}, {24'h0, amplitude_o});
    @(posedge sys_clk_i);
    rd(IDX_EDGE_DURATION, v, rsp);
    chk("reset duration", {24'h0, DUR_RESET}, v);
    rd(IDX_RESIDUAL_LEVEL, v, rsp);
    chk("reset residual", {24'h0, RESIDUAL_RESET}, v);
    rd(IDX_EDGE_KIND, v, rsp);
    chk("reset kind", {24'h0, KIND_RESET}, v);
    rd(IDX_EDGE_PROFILE, v, rsp);
    chk("reset profile", {24'h0, PROFILE_RESET}, v);
    finish_test();
  end
endmodule // active_tx_edge_shaping_cfg_bench
`default_nettype wire
